// file: core/cpio_top.sv
// Local design decisions: the address map and the Wishbone register port.
module cpio_top #(
	parameter int unsigned POR_CYCLES = cpio_pkg::POR_CYC,
	parameter int unsigned STRETCH_CYCLES = cpio_pkg::STRETCH_CYC
) (
	input wire logic core_clk_i, // 125 MHz system clock
	input wire logic rst_n_i, // async reset
	input wire logic wb_cyc_i, // wishbone cycle
	input wire logic wb_stb_i, // wishbone strobe
	input wire logic wb_we_i, // wishbone write
	input wire logic [7:0] wb_adr_i, // byte address
	input wire logic [3:0] wb_sel_i, // byte enables
	input wire logic [31:0] wb_dat_i, // write data
	output logic [31:0] wb_dat_o, // read data
	output logic wb_ack_o, // acknowledge
	output logic [7:0] module_data_o, // module bus data
	output logic module_data_oe_o, // module data drive enable
	output logic [2:0] module_addr_o, // module address hi..lo
	output logic module_addr_oe_o, // module address drive enable
	output logic board_select_a_n_o, // board select a
	output logic board_select_b_n_o, // board select b
	input wire logic [7:0] panel_data_i, // panel data in
	output logic [7:0] panel_data_o, // panel data out
	output logic panel_data_oe_o, // panel buffer drive enable
	output logic panel_clear_n_o, // panel clear
	output logic panel_segment_sel_a_n_o, // segment latch a
	output logic panel_segment_sel_b_n_o, // segment latch b
	output logic panel_segment_sel_c_n_o, // segment latch c
	output logic panel_segment_sel_d_n_o, // segment latch d
	output logic panel_digit_sel_n_o, // digit latch
	input wire logic [15:0] cpu_addr_i, // processor address
	input wire logic cpu_mem_req_i, // processor memory cycle
	output logic [5:0] mem_cs_n_o, // ram,prog32,prog16,cal a,b,c
	output logic option_buf_oe_o, // option buffers enable
	input wire logic option_irq_n_i, // option interrupt in
	output logic cpu_irq4_n_o, // level four interrupt
	input wire logic supply_ok_i, // supply monitor
	output logic cpu_reset_n_o, // processor reset
	input wire logic unleveled_fault_i, // unleveled detector
	input wire logic reverse_power_trip_n_i, // reverse power trip
	output logic trip_irq_n_o, // latched trip to cpu
	input wire logic beat_i, // loop beat pulse
	input wire logic other_unlock_i, // other unlock sources
	input wire logic high_stab_ref_present_n_i, // option
	input wire logic mid_stab_ref_present_n_i, // option
	input wire logic bus_option_present_n_i, // option
	input wire logic option_c_present_n_i, // option
	input wire logic option_d_present_n_i, // option
	input wire logic ref_ext_i, // rear switch at external
	output logic ref_loop_close_n_o, // loop close control
	output logic [6:0] atten_relay_o, // relay energize, 1 = bypass
	output logic proc_buf_en_o, // processor data buffer
	output logic [4:0] aux_ctrl_o // spare control latch bits
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] ctrl;
		logic [6:0] atten;
		logic trip;
		logic trip_irq_n;
		cpio_pkg::cpio_xf_t mb_st;
		logic [3:0] mb_cnt;
		cpio_pkg::cpio_modcmd_t mb;
		logic mb_oe;
		logic [1:0] bsel_n;
		cpio_pkg::cpio_xf_t pn_st;
		logic [3:0] pn_cnt;
		cpio_pkg::cpio_pncmd_t pn;
		logic pn_oe;
		logic [5:0] pn_sel_n;
		logic [7:0] pn_rdata;
		logic ack;
		logic [31:0] rdata;
		logic [5:0] cs_n;
		logic opt_oe;
		logic irq4_n;
		logic ref_close_n;
		logic unlocked_n;
		logic loop_unl;
		logic cpu_rst_n;
	} cpio_state_t;
	cpio_state_t s_q, s_d;
	logic por_active;
	logic stretch_active;
	// ----------------------------------------
	// power-up ramp and beat stretcher
	// ----------------------------------------
	cpio_oneshot #(
		.CYCLES(POR_CYCLES),
		.START_ACTIVE(1'b1)
	) u_por (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.trig_i(1'b0),
		.active_o(por_active)
	);
	cpio_oneshot #(
		.CYCLES(STRETCH_CYCLES),
		.START_ACTIVE(1'b0)
	) u_stretch (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.trig_i(beat_i),
		.active_o(stretch_active)
	);
	function automatic logic [5:0] panel_onehot_n(input logic [2:0] t);
		logic [5:0] v;
		v = 6'h3f;
		if (t <= 3'h5)
			v[t] = 1'b0;
		return v;
	endfunction
	function automatic logic [5:0] mem_decode_n(input logic [15:0] a);
		logic [5:0] v;
		v = 6'h3f;
		if (!a[15])
			v[1] = 1'b0;
		else if (a[15:14] == 2'h2)
			v[2] = 1'b0;
		else
		begin
			case (a[15:11])
				cpio_pkg::MAP_RAM: v[0] = 1'b0;
				cpio_pkg::MAP_CAL_A: v[3] = 1'b0;
				cpio_pkg::MAP_CAL_B: v[4] = 1'b0;
				cpio_pkg::MAP_CAL_C: v[5] = 1'b0;
				default: v = 6'h3f;
			endcase
		end
		return v;
	endfunction
	// ----------------------------------------
	// next state
	// ----------------------------------------
	logic req;
	logic wr_ok;
	logic [31:0] status;
	always_comb
	begin
		s_d = s_q;
		req = wb_cyc_i && wb_stb_i && !s_q.ack;
		wr_ok = req && wb_we_i && wb_sel_i[0];
		s_d.ack = 1'b0;
		s_d.ctrl[cpio_pkg::CTRL_RF_ON] = 1'b0;
		status = 32'h0;
		status[0] = unleveled_fault_i;
		status[1] = s_q.unlocked_n;
		status[2] = s_q.trip;
		status[3] = s_q.loop_unl;
		status[4] = high_stab_ref_present_n_i;
		status[5] = mid_stab_ref_present_n_i;
		status[6] = bus_option_present_n_i;
		status[7] = option_c_present_n_i;
		status[8] = option_d_present_n_i;
		status[9] = ref_ext_i;
		status[cpio_pkg::ST_BUSY_MB] = (s_q.mb_st != cpio_pkg::XF_IDLE);
		status[cpio_pkg::ST_BUSY_PN] = (s_q.pn_st != cpio_pkg::XF_IDLE);
		status[12] = option_irq_n_i;
		status[13] = reverse_power_trip_n_i;
		if (req)
		begin
			case (wb_adr_i)
				cpio_pkg::OFF_CTRL:
				begin
					s_d.ack = 1'b1;
					if (wr_ok)
						s_d.ctrl = wb_dat_i[7:0];
				end
				cpio_pkg::OFF_ATTEN:
				begin
					s_d.ack = 1'b1;
					if (wr_ok)
						s_d.atten = wb_dat_i[6:0];
				end
				cpio_pkg::OFF_MODBUS:
				begin
					if (!wb_we_i)
						s_d.ack = 1'b1;
					else if (s_q.mb_st == cpio_pkg::XF_IDLE)
					begin
						s_d.ack = 1'b1;
						if (wb_sel_i[1:0] == 2'h3 && wb_dat_i[12:11] != 2'h0)
						begin
							s_d.mb = cpio_pkg::cpio_modcmd_t'(wb_dat_i[12:0]);
							s_d.mb_st = cpio_pkg::XF_SETUP;
							s_d.mb_oe = 1'b1;
						end
					end
				end
				cpio_pkg::OFF_PANEL:
				begin
					if (!wb_we_i)
						s_d.ack = 1'b1;
					else if (s_q.pn_st == cpio_pkg::XF_IDLE)
					begin
						s_d.ack = 1'b1;
						if (wb_sel_i[1:0] == 2'h3 && wb_dat_i[10:8] <= 3'h5)
						begin
							s_d.pn = cpio_pkg::cpio_pncmd_t'(wb_dat_i[11:0]);
							s_d.pn_st = cpio_pkg::XF_SETUP;
							s_d.pn_oe = !wb_dat_i[cpio_pkg::PANEL_READ_BIT]
								&& !s_q.ctrl[cpio_pkg::CTRL_PANEL_BUF_N];
						end
					end
				end
				default:
					s_d.ack = 1'b1;
			endcase
			case (wb_adr_i)
				cpio_pkg::OFF_CTRL: s_d.rdata = {24'h0, s_q.ctrl};
				cpio_pkg::OFF_ATTEN: s_d.rdata = {25'h0, s_q.atten};
				cpio_pkg::OFF_MODBUS: s_d.rdata = {19'h0, s_q.mb};
				cpio_pkg::OFF_PANEL: s_d.rdata = {20'h0, s_q.pn};
				cpio_pkg::OFF_STATUS: s_d.rdata = status;
				cpio_pkg::OFF_PANEL_RD: s_d.rdata = {24'h0, s_q.pn_rdata};
				default: s_d.rdata = 32'h0;
			endcase
		end
		// module bus: data first, select a clock later, then hold
		case (s_q.mb_st)
			cpio_pkg::XF_IDLE:
			begin
				s_d.mb_oe = s_d.mb_oe;
			end
			cpio_pkg::XF_SETUP:
			begin
				s_d.bsel_n = ~s_q.mb.sel;
				s_d.mb_cnt = 4'(cpio_pkg::MOD_SEL_CYC);
				s_d.mb_st = cpio_pkg::XF_SEL;
			end
			cpio_pkg::XF_SEL:
			begin
				if (s_q.mb_cnt <= 4'h1)
				begin
					s_d.bsel_n = 2'h3;
					s_d.mb_st = cpio_pkg::XF_HOLD;
				end
				s_d.mb_cnt = s_q.mb_cnt - 4'h1;
			end
			cpio_pkg::XF_HOLD:
			begin
				s_d.mb_oe = 1'b0;
				s_d.mb_st = cpio_pkg::XF_IDLE;
			end
			default:
				s_d.mb_st = cpio_pkg::XF_IDLE;
		endcase
		// front panel access
		case (s_q.pn_st)
			cpio_pkg::XF_IDLE:
				s_d.pn_sel_n = 6'h3f;
			cpio_pkg::XF_SETUP:
			begin
				s_d.pn_sel_n = panel_onehot_n(s_q.pn.target);
				s_d.pn_cnt = 4'(cpio_pkg::PANEL_SEL_CYC);
				s_d.pn_st = cpio_pkg::XF_SEL;
			end
			cpio_pkg::XF_SEL:
			begin
				if (s_q.pn_cnt <= 4'h1)
				begin
					if (s_q.pn.rd)
						s_d.pn_rdata = panel_data_i;
					s_d.pn_sel_n = 6'h3f;
					s_d.pn_st = cpio_pkg::XF_HOLD;
				end
				s_d.pn_cnt = s_q.pn_cnt - 4'h1;
			end
			cpio_pkg::XF_HOLD:
			begin
				s_d.pn_oe = 1'b0;
				s_d.pn_st = cpio_pkg::XF_IDLE;
			end
			default:
				s_d.pn_st = cpio_pkg::XF_IDLE;
		endcase
		// reverse power trip, set wins over rf-on clear
		if (!reverse_power_trip_n_i)
			s_d.trip = 1'b1;
		else if (s_q.ctrl[cpio_pkg::CTRL_RF_ON])
			s_d.trip = 1'b0;
		s_d.trip_irq_n = !s_d.trip;
		s_d.cs_n = cpu_mem_req_i ? mem_decode_n(cpu_addr_i) : 6'h3f;
		s_d.opt_oe = cpu_mem_req_i && cpu_addr_i[15:12] == cpio_pkg::MAP_OPTION;
		s_d.irq4_n = option_irq_n_i || bus_option_present_n_i;
		s_d.ref_close_n = !(ref_ext_i || !high_stab_ref_present_n_i
			|| !mid_stab_ref_present_n_i);
		s_d.unlocked_n = !stretch_active;
		s_d.loop_unl = stretch_active || other_unlock_i;
		s_d.cpu_rst_n = !por_active && supply_ok_i;
		if (por_active)
			s_d.cpu_rst_n = 1'b0;
	end
	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			s_q <= '0;
			s_q.ctrl <= cpio_pkg::CTRL_RST;
			s_q.atten <= cpio_pkg::ATTEN_RST;
			s_q.mb_st <= cpio_pkg::XF_IDLE;
			s_q.pn_st <= cpio_pkg::XF_IDLE;
			s_q.bsel_n <= 2'h3;
			s_q.pn_sel_n <= 6'h3f;
			s_q.cs_n <= 6'h3f;
			s_q.irq4_n <= 1'b1;
			s_q.ref_close_n <= 1'b1;
			s_q.unlocked_n <= 1'b1;
			s_q.trip_irq_n <= 1'b1;
		end
		else
		begin
			s_q <= s_d;
		end
	end
	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign wb_dat_o = s_q.rdata;
	assign wb_ack_o = s_q.ack;
	assign module_data_o = s_q.mb.data;
	assign module_data_oe_o = s_q.mb_oe;
	assign module_addr_o = s_q.mb.addr;
	assign module_addr_oe_o = s_q.mb_oe;
	assign board_select_a_n_o = s_q.bsel_n[0];
	assign board_select_b_n_o = s_q.bsel_n[1];
	assign panel_data_o = s_q.pn.data;
	assign panel_data_oe_o = s_q.pn_oe;
	assign panel_clear_n_o = s_q.pn_sel_n[0];
	assign panel_segment_sel_a_n_o = s_q.pn_sel_n[1];
	assign panel_segment_sel_b_n_o = s_q.pn_sel_n[2];
	assign panel_segment_sel_c_n_o = s_q.pn_sel_n[3];
	assign panel_segment_sel_d_n_o = s_q.pn_sel_n[4];
	assign panel_digit_sel_n_o = s_q.pn_sel_n[5];
	assign mem_cs_n_o = s_q.cs_n;
	assign option_buf_oe_o = s_q.opt_oe;
	assign cpu_irq4_n_o = s_q.irq4_n;
	assign cpu_reset_n_o = s_q.cpu_rst_n;
	assign trip_irq_n_o = s_q.trip_irq_n;
	assign ref_loop_close_n_o = s_q.ref_close_n;
	assign atten_relay_o = s_q.atten;
	assign proc_buf_en_o = s_q.ctrl[cpio_pkg::CTRL_PROC_BUF_EN];
	assign aux_ctrl_o = s_q.ctrl[7:3];
endmodule

// file: core/cpio_pkg.sv
// What this block does
// - byte bus to board latches, one way
// - two board selects, three address lines
// - module bus drivers float when idle
// - board select delayed one clock
// - module address registered for hold margin
// - panel buffer drives only when enabled, addressed
// - one panel select active per access
// - option buffers high-z unless addressed
// - option interrupt active low, inactive if absent
// - six memory chip selects from address
// - cpu reset at power-up and supply low
// - loss resets at once, power-up ramps slowly
// - read faults, options, reference switch
// - control bits held until rewritten, except rf-on which self-clears
// - loop close on external or stable option
// - beat pulse stretched into unlocked status
// - attenuator bits latched, driven continuously
// - processor data buffer enable and isolate
// - seven pads; energized relay bypasses pad
// - reverse trip latched until rf-on
package cpio_pkg;
	// ----------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_ATTEN = 8'h04;
	localparam logic [7:0] OFF_MODBUS = 8'h08;
	localparam logic [7:0] OFF_PANEL = 8'h0c;
	localparam logic [7:0] OFF_STATUS = 8'h10;
	localparam logic [7:0] OFF_PANEL_RD = 8'h14;
	// ----------------------------------------
	// field positions and reset values
	// ----------------------------------------
	localparam int CTRL_PANEL_BUF_N = 0;
	localparam int CTRL_PROC_BUF_EN = 1;
	localparam int CTRL_RF_ON = 2;
	localparam logic [7:0] CTRL_RST = 8'h01;
	localparam logic [6:0] ATTEN_RST = 7'h00;
	localparam int PANEL_READ_BIT = 11;
	localparam int ST_BUSY_MB = 10;
	localparam int ST_BUSY_PN = 11;
	// ----------------------------------------
	// memory map, upper address bits
	// ----------------------------------------
	localparam logic [4:0] MAP_RAM = 5'h18;
	localparam logic [4:0] MAP_CAL_A = 5'h19;
	localparam logic [4:0] MAP_CAL_B = 5'h1a;
	localparam logic [4:0] MAP_CAL_C = 5'h1b;
	localparam logic [3:0] MAP_OPTION = 4'he;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_MHZ = 125;
	localparam int MOD_SEL_NS = 16;
	localparam int PANEL_SEL_NS = 40;
	localparam int STRETCH_US = 10;
	localparam int POR_US = 1000;
	function automatic int ns_to_cyc(input int ns);
		int c;
		c = (ns * CLK_MHZ + 999) / 1000;
		return (c < 1) ? 1 : c;
	endfunction
	localparam int MOD_SEL_CYC = ns_to_cyc(MOD_SEL_NS);
	localparam int PANEL_SEL_CYC = ns_to_cyc(PANEL_SEL_NS);
	localparam int STRETCH_CYC = STRETCH_US * CLK_MHZ;
	localparam int POR_CYC = POR_US * CLK_MHZ;
	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {XF_IDLE, XF_SETUP, XF_SEL, XF_HOLD} cpio_xf_t;
	typedef struct packed {
		logic [1:0] sel;
		logic [2:0] addr;
		logic [7:0] data;
	} cpio_modcmd_t;
	typedef struct packed {
		logic rd;
		logic [2:0] target;
		logic [7:0] data;
	} cpio_pncmd_t;
endpackage

// file: core/cpio_oneshot.sv
module cpio_oneshot #(
	parameter int unsigned CYCLES = 16,
	parameter bit START_ACTIVE = 1'b0
) (
	input wire logic core_clk_i, // system clock
	input wire logic rst_n_i, // async reset
	input wire logic trig_i, // (re)start the pulse
	output logic active_o // high while pulse runs
);
	typedef struct packed {
		logic [31:0] cnt;
		logic active;
	} cpio_os_t;
	cpio_os_t s_q, s_d;
	always_comb
	begin
		s_d = s_q;
		if (trig_i)
		begin
			s_d.cnt = 32'(CYCLES);
			s_d.active = 1'b1;
		end
		else if (s_q.cnt != 32'h0)
		begin
			s_d.cnt = s_q.cnt - 32'h1;
			s_d.active = (s_q.cnt != 32'h1);
		end
		else
		begin
			s_d.active = 1'b0;
		end
	end
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			s_q.cnt <= START_ACTIVE ? 32'(CYCLES) : 32'h0;
			s_q.active <= START_ACTIVE;
		end
		else
		begin
			s_q <= s_d;
		end
	end
	assign active_o = s_q.active;
endmodule

// file: dv/cpio_props.sv
module cpio_props (
	input wire logic core_clk_i, // clock
	input wire logic rst_n_i, // reset
	input wire logic module_data_oe_o, // bus drive
	input wire logic [2:0] module_addr_o, // latch address
	input wire logic board_select_a_n_o, // select a
	input wire logic board_select_b_n_o, // select b
	input wire logic [15:0] cpu_addr_i, // cpu address
	input wire logic cpu_mem_req_i, // memory cycle
	input wire logic [5:0] mem_cs_n_o, // chip selects
	input wire logic option_buf_oe_o, // option buffers
	input wire logic option_irq_n_i, // option irq
	input wire logic bus_option_present_n_i, // option fitted
	input wire logic cpu_irq4_n_o, // level four irq
	input wire logic supply_ok_i, // supply good
	input wire logic cpu_reset_n_o, // cpu reset
	input wire logic reverse_power_trip_n_i, // trip in
	input wire logic trip_irq_n_o // trip latched
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	// ------------------------------
	// module bus
	// ------------------------------
	chk_idle_release: assert property (
		!module_data_oe_o |-> board_select_a_n_o && board_select_b_n_o)
		else $error("board select while bus released");
	chk_sel_setup: assert property (
		$fell(board_select_a_n_o) || $fell(board_select_b_n_o) |-> $past(module_data_oe_o))
		else $error("select fell without setup cycle");
	chk_sel_width: assert property (
		$fell(board_select_a_n_o) |=> !board_select_a_n_o ##1 board_select_a_n_o)
		else $error("select a not two cycles");
	chk_addr_hold: assert property (
		$rose(board_select_a_n_o) || $rose(board_select_b_n_o) |->
		module_data_oe_o && $stable(module_addr_o))
		else $error("address not held past select");
	// ------------------------------
	// decode, irq, reset, trip
	// ------------------------------
	chk_ram_select: assert property (
		cpu_mem_req_i && cpu_addr_i[15:11] == 5'h18 |=> mem_cs_n_o == 6'h3e)
		else $error("ram select wrong");
	chk_option_quiet: assert property (
		!cpu_mem_req_i |=> !option_buf_oe_o)
		else $error("option buffers on while idle");
	chk_irq_absent: assert property (
		bus_option_present_n_i |=> cpu_irq4_n_o)
		else $error("irq active with option absent");
	chk_irq_pass: assert property (
		!option_irq_n_i && !bus_option_present_n_i |=> !cpu_irq4_n_o)
		else $error("option irq not passed");
	chk_supply_drop: assert property (
		!supply_ok_i && cpu_reset_n_o |=> !cpu_reset_n_o)
		else $error("reset late on supply loss");
	chk_trip_latch: assert property (
		$fell(reverse_power_trip_n_i) |=> !trip_irq_n_o [*2])
		else $error("trip not latched");
endmodule

// file: dv/cpio_board_model.sv
module cpio_board_model (
	input wire logic core_clk_i, // clock
	input wire logic [7:0] mod_data_i, // bus data
	input wire logic mod_oe_i, // bus driven
	input wire logic [2:0] mod_addr_i, // latch address
	input wire logic [1:0] mod_sel_n_i, // selects b,a
	input wire logic [5:0] pn_sel_n_i, // panel selects
	input wire logic [7:0] pn_rd_i, // byte panel returns
	output logic [7:0] panel_data_o // panel read data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] latch_q [4][8];
	logic [1:0] sel_q = 2'h3;
	logic [7:0] junk_q = 8'h5a;
	// ------------------------------
	// latches close as select ends
	// ------------------------------
	always @(posedge core_clk_i)
	begin
		junk_q <= ~junk_q;
		sel_q <= mod_sel_n_i;
		if ((~sel_q & mod_sel_n_i) != 2'h0)
			latch_q[~sel_q][mod_addr_i] <= mod_oe_i ? mod_data_i : junk_q;
	end
	// released panel lines float, seen as junk
	assign panel_data_o = (&pn_sel_n_i) ? junk_q : pn_rd_i;
endmodule

// file: dv/test_controller_peripheral_io.sv
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin err_total++; \
	$display("[FAIL] %s exp %0h got %0h", n, e, s); end end
module test_controller_peripheral_io;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int POR = 20;
	localparam int STR = 10;
	localparam logic [15:0] BASE [7] = '{16'h0, 16'h8000, 16'hc000, 16'hc800, 16'hd000,
		16'hd800, 16'he000};
	localparam logic [5:0] CS [7] = '{6'h3d, 6'h3b, 6'h3e, 6'h37, 6'h2f, 6'h1f, 6'h3f};
	logic core_clk_i, rst_n_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, cpu_mem_req_i;
	logic [7:0] wb_adr_i, panel_data_i, panel_data_o, module_data_o, pn_rd, pn_dat, d, c;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, q, r, p;
	logic module_data_oe_o, module_addr_oe_o, board_select_a_n_o, board_select_b_n_o;
	logic [2:0] module_addr_o, ad;
	logic panel_data_oe_o, panel_clear_n_o, panel_digit_sel_n_o, option_buf_oe_o;
	logic panel_segment_sel_a_n_o, panel_segment_sel_b_n_o, panel_segment_sel_c_n_o;
	logic panel_segment_sel_d_n_o, option_irq_n_i, cpu_irq4_n_o, supply_ok_i;
	logic [15:0] cpu_addr_i;
	logic [5:0] mem_cs_n_o, pn_sel, pn_hit;
	logic cpu_reset_n_o, unleveled_fault_i, trip_irq_n_o, reverse_power_trip_n_i, beat_i;
	logic other_unlock_i, ref_ext_i, ref_loop_close_n_o, high_stab_ref_present_n_i;
	logic mid_stab_ref_present_n_i, bus_option_present_n_i, option_c_present_n_i;
	logic option_d_present_n_i, proc_buf_en_o;
	logic [6:0] atten_relay_o, a7;
	logic [4:0] aux_ctrl_o;
	logic [1:0] s;
	int err_total = 0;
	int comparisons = 0;
	int pn_oe = 0;
	assign wb_stb_i = wb_cyc_i;
	assign pn_sel = ~{panel_digit_sel_n_o, panel_segment_sel_d_n_o, panel_segment_sel_c_n_o,
		panel_segment_sel_b_n_o, panel_segment_sel_a_n_o, panel_clear_n_o};
	cpio_top #(.POR_CYCLES(POR), .STRETCH_CYCLES(STR)) dut (.*);
	cpio_board_model u_brd (.core_clk_i(core_clk_i), .mod_data_i(module_data_o),
		.mod_oe_i(module_data_oe_o & module_addr_oe_o), .mod_addr_i(module_addr_o),
		.mod_sel_n_i({board_select_b_n_o, board_select_a_n_o}), .pn_sel_n_i(~pn_sel),
		.pn_rd_i(pn_rd), .panel_data_o(panel_data_i));
	initial
	begin
		core_clk_i = 1'b0;
		forever #4 core_clk_i = ~core_clk_i;
	end
	always @(posedge core_clk_i)
	begin
		if (panel_data_oe_o === 1'b1)
		begin
			pn_oe++;
			pn_dat = panel_data_o;
		end
	end
	task automatic clk(input int n);
		repeat (n) @(posedge core_clk_i);
	endtask
	// collects every panel select seen over n cycles
	task automatic watch(input int n);
		repeat (n)
		begin
			@(posedge core_clk_i);
			pn_hit = pn_hit | pn_sel;
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
		wb_cyc_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_sel_i <= 4'hf;
		wb_dat_i <= v;
		do
			@(posedge core_clk_i);
		while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		@(posedge core_clk_i);
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		clk(6000);
		err_total++;
		finish_test();
	end
	// ------------------------------
	// main sequence
	// ------------------------------
	initial
	begin
		void'($urandom(18));
		{rst_n_i, wb_cyc_i, wb_we_i, wb_adr_i, wb_dat_i, cpu_addr_i, pn_rd} <= '0;
		wb_sel_i <= 4'hf;
		{cpu_mem_req_i, unleveled_fault_i, beat_i, other_unlock_i, ref_ext_i} <= 5'h0;
		{option_irq_n_i, supply_ok_i, reverse_power_trip_n_i} <= 3'h7;
		{option_d_present_n_i, option_c_present_n_i, bus_option_present_n_i,
			mid_stab_ref_present_n_i, high_stab_ref_present_n_i} <= 5'h1f;
		clk(16);
		rst_n_i <= 1'b1;
		clk(POR - 2);
		`CHK("por", 1'b0, cpu_reset_n_o)
		clk(6);
		`CHK("por end", 1'b1, cpu_reset_n_o)
		wb(1'b0, cpio_pkg::OFF_CTRL, 0);
		`CHK("ctrl rst", cpio_pkg::CTRL_RST, q[7:0])
		`CHK("pbuf rst", 1'b0, proc_buf_en_o)
		wb(1'b0, 8'h20, 0);
		`CHK("unmapped", 32'h0, q)
		wb(1'b1, cpio_pkg::OFF_PANEL, 32'h1aa);
		clk(10);
		`CHK("pn off", 0, pn_oe)
		c = {5'($urandom), 3'h2};
		wb(1'b1, cpio_pkg::OFF_CTRL, {24'h0, c});
		wb(1'b0, cpio_pkg::OFF_CTRL, 0);
		`CHK("ctrl", c, q[7:0])
		`CHK("aux", c[7:3], aux_ctrl_o)
		`CHK("pbuf", 1'b1, proc_buf_en_o)
		a7 = 7'($urandom);
		wb(1'b1, cpio_pkg::OFF_ATTEN, {25'h0, a7});
		`CHK("atten", a7, atten_relay_o)
		for (int t = 0; t < 6; t++)
		begin
			d = 8'($urandom);
			pn_rd <= 8'($urandom);
			pn_hit = 6'h0;
			wb(1'b1, cpio_pkg::OFF_PANEL, {21'h0, 3'(t), d});
			watch(10);
			`CHK("pn sel", 6'(1 << t), pn_hit)
			`CHK("pn dat", d, pn_dat)
			wb(1'b1, cpio_pkg::OFF_PANEL, {20'h0, 1'b1, 3'(t), 8'h0});
			clk(10);
			wb(1'b0, cpio_pkg::OFF_PANEL_RD, 0);
			`CHK("pn rd", pn_rd, q[7:0])
		end
		pn_hit = 6'h0;
		wb(1'b1, cpio_pkg::OFF_PANEL, {21'h0, 3'h6, d});
		watch(10);
		`CHK("pn none", 6'h0, pn_hit)
		for (int i = 0; i < 3; i++)
		begin
			s = 2'(i + 1);
			ad = 3'($urandom);
			d = 8'($urandom);
			wb(1'b1, cpio_pkg::OFF_MODBUS, {19'h0, s, ad, d});
			wb(1'b1, cpio_pkg::OFF_MODBUS, {19'h0, s, ad + 3'h1, ~d});
			clk(7);
			`CHK("latch", d, u_brd.latch_q[s][ad])
			`CHK("latch 2", ~d, u_brd.latch_q[s][ad + 3'h1])
			`CHK("release", 2'b00, {module_addr_oe_o, module_data_oe_o})
		end
		wb(1'b1, cpio_pkg::OFF_MODBUS, {19'h0, 2'h0, ad, d});
		`CHK("no xfer", 1'b0, module_data_oe_o)
		wb(1'b0, cpio_pkg::OFF_MODBUS, 0);
		`CHK("mb cmd", {s, ad + 3'h1, ~d}, q[12:0])
		for (int i = 0; i < 7; i++)
		begin
			cpu_addr_i <= BASE[i] | 16'($urandom & 32'h7ff);
			cpu_mem_req_i <= 1'b1;
			clk(2);
			`CHK("cs", CS[i], mem_cs_n_o)
			`CHK("opt oe", 1'(i == 6), option_buf_oe_o)
		end
		cpu_mem_req_i <= 1'b0;
		clk(2);
		`CHK("cs idle", 6'h3f, mem_cs_n_o)
		for (int i = 0; i < 8; i++)
		begin
			r = $urandom;
			{ref_ext_i, unleveled_fault_i, option_irq_n_i} <= r[2:0];
			{option_d_present_n_i, option_c_present_n_i, bus_option_present_n_i,
				mid_stab_ref_present_n_i, high_stab_ref_present_n_i} <= r[7:3];
			clk(3);
			wb(1'b0, cpio_pkg::OFF_STATUS, 0);
			`CHK("st opt", {r[2], r[7:3]}, q[9:4])
			`CHK("st lvl", r[1], q[0])
			p = q;
			wb(1'b0, cpio_pkg::OFF_STATUS, 0);
			`CHK("st again", p, q)
			`CHK("close", ~(r[2] | ~r[3] | ~r[4]), ref_loop_close_n_o)
			`CHK("irq4", r[0] | r[5], cpu_irq4_n_o)
		end
		beat_i <= 1'b1;
		clk(1);
		beat_i <= 1'b0;
		clk(3);
		wb(1'b0, cpio_pkg::OFF_STATUS, 0);
		`CHK("unlk", 2'b10, {q[3], q[1]})
		clk(STR + 4);
		wb(1'b0, cpio_pkg::OFF_STATUS, 0);
		`CHK("unlk end", 2'b01, {q[3], q[1]})
		{reverse_power_trip_n_i, other_unlock_i} <= 2'b01;
		clk(1);
		reverse_power_trip_n_i <= 1'b1;
		clk(3);
		wb(1'b0, cpio_pkg::OFF_STATUS, 0);
		`CHK("trip", 3'b011, {trip_irq_n_o, q[2], q[3]})
		other_unlock_i <= 1'b0;
		wb(1'b1, cpio_pkg::OFF_CTRL, {24'h0, c | 8'h4});
		clk(2);
		`CHK("rf on", 1'b1, trip_irq_n_o)
		supply_ok_i <= 1'b0;
		clk(2);
		`CHK("sup low", 1'b0, cpu_reset_n_o)
		supply_ok_i <= 1'b1;
		clk(3);
		`CHK("sup ok", 1'b1, cpu_reset_n_o)
		finish_test();
	end
endmodule
bind cpio_top cpio_props u_props (.*);
